// *** verification/cswd_ext_dev.sv ***
/*
 * Slow external device: stretches an access by holding the wait pin.
 * Assumes the wait pin has a pull-up, so it idles high.
 */
`timescale 1ns/1ps
`default_nettype none
module cswd_ext_dev (
   input  wire logic       aclk,
   input  wire logic [3:0] select_line_n,
   input  wire logic [3:0] hold_cycles,
   output logic            wait_n
);
   logic [3:0] prev_r = 4'hf;
   logic       pin_r  = 1'b1;
   int         left   = 0;
   assign wait_n = pin_r;

   // ==========================================================
   // Wait pin
   // ==========================================================
   // hold then release
   always @(posedge aclk) begin
      prev_r <= select_line_n;
      if (left > 1) begin
         left <= left - 1;
      end else if (left == 1) begin
         left <= 0;
         pin_r <= 1'b1;
      end else if (select_line_n != 4'hf && prev_r == 4'hf && hold_cycles != 4'h0) begin
         left <= int'(hold_cycles);
         pin_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** verification/cswd_props.sv ***
/*
 * Checker for the chip-select decoder ports: select exclusivity,
 * strobes, idle level, peripheral window and stall length.
 * Assumes binding into cswd_decoder with clk_en held high.
 */
`timescale 1ns/1ps
`default_nettype none
module cswd_props (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        clk_en,
   input wire logic [23:0] cpu_addr,
   input wire logic        cpu_mem_access,
   input wire logic        cpu_io_access,
   input wire logic        cpu_write,
   input wire logic        cpu_stall,
   input wire logic        bus_granted,
   input wire logic        wait_n,
   input wire logic [3:0]  select_line_n,
   input wire logic        memory_request_strobe_n,
   input wire logic        io_request_strobe_n,
   input wire logic        read_strobe_n,
   input wire logic        write_strobe_n
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !clk_en);

   // ==========================================================
   // Stall run length
   // ==========================================================
   // Restarts on a low wait pin; the sync lag adds up to three
   logic [4:0] stall_run_r;
   always_ff @(posedge aclk) begin
      if (!aresetn || !cpu_stall || !wait_n) begin
         stall_run_r <= 5'h00;
      end else if (stall_run_r != 5'h1f) begin
         stall_run_r <= stall_run_r + 5'h01;
      end
   end

   // ==========================================================
   // Properties
   // ==========================================================
   a_one_select: assert property ($onehot0(~select_line_n))
      else $error("two selects low at once");
   a_space_strobe: assert property ((select_line_n != 4'hf) |->
      (memory_request_strobe_n ^ io_request_strobe_n)) else $error("space strobe wrong");
   a_dir_strobe: assert property ((select_line_n != 4'hf) |->
      (read_strobe_n ^ write_strobe_n)) else $error("read write strobe wrong");
   a_idle_high: assert property ((!cpu_mem_access && !cpu_io_access && !bus_granted)[*4]
      |=> select_line_n == 4'hf) else $error("select low while idle");
   a_periph_skip: assert property ((cpu_io_access && !cpu_mem_access && !bus_granted
      && cpu_addr[15:7] == 9'h001) |=> select_line_n == 4'hf) else $error("select in window");
   a_mem_write: assert property ((cpu_mem_access && !cpu_io_access && !bus_granted)
      |=> select_line_n == 4'hf || (!memory_request_strobe_n
      && write_strobe_n == !$past(cpu_write))) else $error("memory strobes wrong");
   a_stall_bound: assert property (stall_run_r <= 5'h0a)
      else $error("stall too long");
   a_stall_cause: assert property ($rose(cpu_stall) |->
      $past(cpu_mem_access) || $past(cpu_io_access)) else $error("stall without access");

   c_sel0: cover property (select_line_n == 4'he);
   c_io: cover property (!io_request_strobe_n && select_line_n != 4'hf);
   c_stall_end: cover property ($fell(cpu_stall));
endmodule

bind cswd_decoder cswd_props i_cswd_props (.*);
`default_nettype wire

// *** verification/tb.sv ***
/*
 * Self-checking bench for the chip-select decoder: registers, decode
 * against a model, wait states, wait pin and bus grant.
 * Assumes cswd_ext_dev drives the wait pin.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ==========================================================
   // Signals and model state
   // ==========================================================
   logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf, select_line_n, hold = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_stall, wait_n;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [23:0] cpu_addr = 24'h0, ext_addr = 24'h0;
   logic cpu_mem_access = 1'b0, cpu_io_access = 1'b0, cpu_write = 1'b0;
   logic bus_granted = 1'b0, ext_mem_access = 1'b0, ext_io_access = 1'b0, ext_write = 1'b0;
   logic memory_request_strobe_n, io_request_strobe_n, read_strobe_n, write_strobe_n;
   int ctl[4], lo[4], hi[4];
   int fails = 0, comparisons = 0;
   logic [31:0] rng = 32'hbd5f;

   cswd_decoder i_cswd_decoder (.*);
   cswd_ext_dev i_cswd_ext_dev (.aclk(aclk), .select_line_n(select_line_n),
      .hold_cycles(hold), .wait_n(wait_n));

   always #5 aclk = ~aclk;

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // Lowest numbered enabled match wins
   function automatic logic [3:0] exp_sel(input int m, input int io, input logic [23:0] a);
      for (int i = 0; i < 4; i++) begin
         if (ctl[i][3] && ((m && !ctl[i][4] && lo[i] <= a[23:16] && a[23:16] <= hi[i])
             || (io && ctl[i][4] && a[15:8] == lo[i] && a[15:7] != 9'h001))) return ~(4'h1 << i);
      end
      return 4'hf;
   endfunction

   function automatic logic [7:0] ra(input int i, input logic [7:0] o);
      return o + 8'(i * cswd_pkg::CSWD_SEL_STRIDE);
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic axw(input logic [7:0] a, input int d);
      logic aw, w, b;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= 32'(d);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b = 1'b0;
      r = 2'h3;
      while (!b) begin
         #1;
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) s_axi_bready <= 1'b0;
      end
      chk("bresp", r, cswd_pkg::CSWD_RESP_OKAY);
   endtask

   task automatic axr(input logic [7:0] a, input int e, input logic [1:0] er);
      logic ar, rv;
      logic [1:0] r;
      logic [31:0] d;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      rv = 1'b0;
      r = 2'h3;
      while (!rv) begin
         #1;
         ar = s_axi_arvalid && s_axi_arready;
         rv = s_axi_rvalid && s_axi_rready;
         r = s_axi_rresp;
         d = s_axi_rdata;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
         if (rv) s_axi_rready <= 1'b0;
      end
      chk("rresp", r, er);
      if (er == cswd_pkg::CSWD_RESP_OKAY) chk("rdata", d, 32'(e));
   endtask

   task automatic cfg(input int i, input int c, input int l, input int h);
      ctl[i] = c;
      lo[i] = l;
      hi[i] = h;
      axw(ra(i, cswd_pkg::CSWD_CTL_OFS), c);
      axw(ra(i, cswd_pkg::CSWD_LOWER_OFS), l);
      axw(ra(i, cswd_pkg::CSWD_UPPER_OFS), h);
   endtask

   // One CPU access; n returns the stall length
   task automatic acc(input int m, input int io, input int wr, input logic [23:0] a,
                      output int n);
      logic [3:0] e;
      e = exp_sel(m, io, a);
      @(posedge aclk);
      cpu_mem_access <= 1'(m);
      cpu_io_access <= 1'(io);
      cpu_write <= 1'(wr);
      cpu_addr <= a;
      @(posedge aclk);
      #1;
      chk("select", select_line_n, e);
      chk("strobes", {memory_request_strobe_n, io_request_strobe_n, read_strobe_n,
         write_strobe_n}, (e == 4'hf) ? 4'hf : {1'(!m), 1'(!io), 1'(wr), 1'(!wr)});
      n = 0;
      while (cpu_stall === 1'b1 && n < 40) begin
         n++;
         @(posedge aclk);
         #1;
      end
      @(posedge aclk);
      cpu_mem_access <= 1'b0;
      cpu_io_access <= 1'b0;
      #1;
      chk("no_rearm", cpu_stall, 1'b0);
      repeat (12) @(posedge aclk);
   endtask

   task automatic print_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Watchdog far beyond the expected few thousand cycles
   initial begin
      repeat (40000) @(posedge aclk);
      fails++;
      print_verdict();
   end

   // ==========================================================
   // Tests
   // ==========================================================
   initial begin
      int n;
      int m;
      logic [23:0] a;
      for (int i = 0; i < 4; i++) begin
         ctl[i] = 0;
         lo[i] = 0;
         hi[i] = (i == 0) ? 255 : 0;
      end
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         axr(ra(i, cswd_pkg::CSWD_CTL_OFS), ctl[i], cswd_pkg::CSWD_RESP_OKAY);
         axr(ra(i, cswd_pkg::CSWD_LOWER_OFS), lo[i], cswd_pkg::CSWD_RESP_OKAY);
         axr(ra(i, cswd_pkg::CSWD_UPPER_OFS), hi[i], cswd_pkg::CSWD_RESP_OKAY);
      end
      axr(8'h0c, 0, cswd_pkg::CSWD_RESP_SLVERR);
      axr(cswd_pkg::CSWD_STATUS_OFS, 32'h0f, cswd_pkg::CSWD_RESP_OKAY);
      acc(1, 0, 0, 24'h123456, n);
      $display("test reset_values done");
      for (int k = 0; k < 6; k++) begin
         for (int i = 0; i < 4; i++) begin
            m = xs();
            cfg(i, m & 32'h18, m[31] ? 0 : m[15:8], m[20] ? m[15:8] : m[23:16]);
            axr(ra(i, cswd_pkg::CSWD_CTL_OFS), ctl[i], cswd_pkg::CSWD_RESP_OKAY);
         end
         for (int j = 0; j < 24; j++) begin
            m = xs();
            a = m[23:0];
            if (m[25]) a[23:8] = {8'(hi[m[27:26]]), 8'(lo[m[27:26]])};
            if (m[28]) a[15:7] = 9'h001;
            acc(m[30], !m[30], m[24], a, n);
         end
      end
      $display("test random_decode done");
      for (int w = 0; w < 8; w++) begin
         cfg(0, w * 32 + 8, 0, 255);
         acc(1, 0, w & 1, 24'h400000, n);
         chk("stall", n, w);
      end
      hold <= 4'hc;
      acc(1, 0, 0, 24'h400000, n);
      chk("wait_pin", n > 10 && n < 20, 1);
      hold <= 4'h0;
      $display("test wait_states done");
      cfg(0, 0, 0, 255);
      cfg(1, 8, 32, 47);
      @(posedge aclk);
      bus_granted <= 1'b1;
      ext_mem_access <= 1'b1;
      ext_write <= 1'b1;
      ext_addr <= 24'h2a0000;
      repeat (5) @(posedge aclk);
      #1;
      chk("grant_select", select_line_n, exp_sel(1, 0, 24'h2a0000));
      chk("grant_write", write_strobe_n, 1'b0);
      @(posedge aclk);
      bus_granted <= 1'b0;
      ext_mem_access <= 1'b0;
      repeat (8) @(posedge aclk);
      $display("test bus_grant done");
      print_verdict();
   end
endmodule
`default_nettype wire

// *** verilog/cswd_decoder.sv ***
/*
 * Chip-select and wait-state decoder: four active-low selects decoded
 * from CPU bus cycles, memory or I/O space, with programmable waits.
 * Assumes cpu_* access inputs come from logic on aclk; the external
 * wait_n pin and bus-grant address arrive asynchronously and are
 * synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Four independent active-low selects, each in memory or I/O space only.
// - Control bit 4 picks memory (0) or I/O (1); reset is memory space.
// - A select asserts only when its control bit 3 enable is 1.
// - A memory select matches when address bits 23:16 lie within its bounds.
// - Memory selects assert only during memory accesses, with memory strobe and read/write.
// - When several selects match, only the lowest-numbered one asserts.
// - Equal lower and upper bounds cover exactly one 64 KB page.
// - Select 0 resets to bounds 00h..FFh; all other bounds reset to 00h.
// - I/O selects assert only during I/O cycles, with I/O strobe and read/write.
// - I/O decode compares address bits 15:8 to the lower bound, ignoring 23:16 and page base.
// - No I/O select asserts for I/O addresses 0080h through 00FFh.
// - Each select has a 3-bit wait count in control bits 7:5.
// - The CPU is stalled for exactly the programmed 0 to 7 cycles per access preceded by an idle cycle.
// - A low external wait input, sampled at the last programmed wait cycle, adds cycles; resume on the third edge after release.
// - While the bus is granted away, the external address keeps being decoded.
module cswd_decoder #(
   parameter int NUM_SEL = 4
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clk_en,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // CPU side access qualifiers
   input  wire logic [23:0] cpu_addr,
   input  wire logic        cpu_mem_access,
   input  wire logic        cpu_io_access,
   input  wire logic        cpu_write,
   output logic             cpu_stall,
   // Bus grant to an external master
   input  wire logic        bus_granted,
   input  wire logic [23:0] ext_addr,
   input  wire logic        ext_mem_access,
   input  wire logic        ext_io_access,
   input  wire logic        ext_write,
   // External pins
   input  wire logic        wait_n,
   output logic [3:0]       select_line_n,
   output logic             memory_request_strobe_n,
   output logic             io_request_strobe_n,
   output logic             read_strobe_n,
   output logic             write_strobe_n
);

   // Priority mask and register map are laid out for exactly four selects
   if (NUM_SEL != 4) begin : g_bad_sel
      $error("cswd_decoder supports exactly four selects");
   end

   // ==========================================================
   // Register storage
   // ==========================================================
   logic [7:0] select_control_r     [NUM_SEL];
   logic [7:0] select_lower_bound_r [NUM_SEL];
   logic [7:0] select_upper_bound_r [NUM_SEL];

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   logic        wait_meta_r;
   logic        wait_sync_r;
   logic [27:0] ext_meta_r;
   logic [27:0] ext_sync_r;

   // Two flops on every pin-side input before any logic looks at it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_meta_r <= 1'b1;
         wait_sync_r <= 1'b1;
         ext_meta_r  <= 28'h0000000;
         ext_sync_r  <= 28'h0000000;
      end else if (clk_en) begin
         wait_meta_r <= wait_n;
         wait_sync_r <= wait_meta_r;
         ext_meta_r  <= {bus_granted, ext_write, ext_io_access, ext_mem_access, ext_addr};
         ext_sync_r  <= ext_meta_r;
      end
   end

   // ==========================================================
   // Access source selection
   // ==========================================================
   logic        grant_s;
   logic [23:0] acc_addr;
   logic        acc_mem;
   logic        acc_io;
   logic        acc_wr;

   assign grant_s  = ext_sync_r[27];
   assign acc_addr = grant_s ? ext_sync_r[23:0] : cpu_addr;
   assign acc_mem  = grant_s ? ext_sync_r[24]   : cpu_mem_access;
   assign acc_io   = grant_s ? ext_sync_r[25]   : cpu_io_access;
   assign acc_wr   = grant_s ? ext_sync_r[26]   : cpu_write;

   // ==========================================================
   // Per-select match
   // ==========================================================
   logic [NUM_SEL-1:0] hit;
   logic               periph_hit;

   assign periph_hit = (acc_addr[15:0] >= cswd_pkg::CSWD_PERIPH_LO)
                    && (acc_addr[15:0] <= cswd_pkg::CSWD_PERIPH_HI);

   genvar gi;
   generate
      for (gi = 0; gi < NUM_SEL; gi++) begin : g_match
         logic en_b;
         logic io_b;
         assign en_b = select_control_r[gi][cswd_pkg::CSWD_ENABLE_BIT];
         assign io_b = select_control_r[gi][cswd_pkg::CSWD_SPACE_BIT];
         // inclusive range or I/O byte compare
         assign hit[gi] = en_b && (io_b
            ? (acc_io && !periph_hit && acc_addr[15:8] == select_lower_bound_r[gi])
            : (acc_mem && acc_addr[23:16] >= select_lower_bound_r[gi]
                       && acc_addr[23:16] <= select_upper_bound_r[gi]));
      end
   endgenerate

   logic [NUM_SEL-1:0] win;
   assign win = hit & (~hit + 4'h1);

   // ==========================================================
   // Pin outputs and wait sequencing
   // ==========================================================
   cswd_pkg::cswd_state_t state_r;
   logic [2:0]            wait_cnt_r;
   logic [2:0]            win_wait;
   logic                  acc_live;
   logic                  served_r;

   // Wait count of the winning select
   always_comb begin
      win_wait = 3'h0;
      for (int i = NUM_SEL - 1; i >= 0; i--) begin
         if (win[i]) begin
            win_wait = select_control_r[i][cswd_pkg::CSWD_WAIT_MSB:cswd_pkg::CSWD_WAIT_LSB];
         end
      end
   end

   assign acc_live = |win;

   // one stall per access
   // A held access would re-arm the count after it ran; the selects must
   // go idle between accesses, so gapless back-to-back accesses get no wait
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         served_r <= 1'b0;
      end else if (clk_en) begin
         if (!acc_live) begin
            served_r <= 1'b0;
         end else if (state_r != cswd_pkg::CSWD_IDLE) begin
            served_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         select_line_n           <= 4'hf;
         memory_request_strobe_n <= 1'b1;
         io_request_strobe_n     <= 1'b1;
         read_strobe_n           <= 1'b1;
         write_strobe_n          <= 1'b1;
      end else if (clk_en) begin
         select_line_n           <= ~win;
         memory_request_strobe_n <= ~(acc_live && acc_mem);
         io_request_strobe_n     <= ~(acc_live && acc_io);
         read_strobe_n           <= ~(acc_live && !acc_wr);
         write_strobe_n          <= ~(acc_live && acc_wr);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r    <= cswd_pkg::CSWD_IDLE;
         wait_cnt_r <= 3'h0;
      end else if (clk_en) begin
         unique case (state_r)
            cswd_pkg::CSWD_IDLE: begin
               if (acc_live && !grant_s && !served_r) begin
                  wait_cnt_r <= win_wait;
                  state_r    <= (win_wait != 3'h0) ? cswd_pkg::CSWD_WAITING
                                                   : cswd_pkg::CSWD_IDLE;
               end
            end
            cswd_pkg::CSWD_WAITING: begin
               if (wait_cnt_r == 3'h1) begin
                  state_r <= wait_sync_r ? cswd_pkg::CSWD_IDLE : cswd_pkg::CSWD_EXTEND;
               end
               wait_cnt_r <= wait_cnt_r - 3'h1;
            end
            cswd_pkg::CSWD_EXTEND: begin
               if (wait_sync_r) begin
                  state_r <= cswd_pkg::CSWD_IDLE;
               end
            end
            default: state_r <= cswd_pkg::CSWD_IDLE;
         endcase
      end
   end

   // Stall covers the programmed count and any external extension
   assign cpu_stall = (state_r != cswd_pkg::CSWD_IDLE);

   // ==========================================================
   // AXI4-Lite slave
   // ==========================================================
   logic       aw_held_r;
   logic       w_held_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic       do_write;
   logic [7:0] wr_ofs;
   logic [1:0] wr_sel;
   logic       wr_ok;

   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
   assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;
   assign wr_ofs        = aw_addr_r & 8'h0f;
   assign wr_sel        = aw_addr_r[5:4];
   assign wr_ok         = (aw_addr_r[7:6] == 2'h0) && (aw_addr_r[1:0] == 2'h0)
                       && (wr_ofs <= cswd_pkg::CSWD_UPPER_OFS);

   // Address and data captured independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r    <= 1'b0;
         w_held_r     <= 1'b0;
         aw_addr_r    <= 8'h00;
         w_data_r     <= 32'h00000000;
         w_strb_r     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= cswd_pkg::CSWD_RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? cswd_pkg::CSWD_RESP_OKAY : cswd_pkg::CSWD_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // bound and control reset values; byte lane 0 holds data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_SEL; i++) begin
            select_control_r[i]     <= cswd_pkg::CSWD_CTL_RST;
            select_lower_bound_r[i] <= cswd_pkg::CSWD_LOWER_RST;
            select_upper_bound_r[i] <= (i == 0) ? cswd_pkg::CSWD_UPPER0_RST
                                                : cswd_pkg::CSWD_UPPER_RST;
         end
      end else if (clk_en && do_write && wr_ok && w_strb_r[0]) begin
         unique case (wr_ofs)
            cswd_pkg::CSWD_CTL_OFS:   select_control_r[wr_sel]     <= w_data_r[7:0];
            cswd_pkg::CSWD_LOWER_OFS: select_lower_bound_r[wr_sel] <= w_data_r[7:0];
            cswd_pkg::CSWD_UPPER_OFS: select_upper_bound_r[wr_sel] <= w_data_r[7:0];
            default: ;
         endcase
      end
   end

   // Read path: one cycle from address to data
   logic [7:0] rd_ofs;
   logic [1:0] rd_sel;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_ofs        = s_axi_araddr & 8'h0f;
   assign rd_sel        = s_axi_araddr[5:4];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= cswd_pkg::CSWD_RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= cswd_pkg::CSWD_RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
            if (s_axi_araddr == cswd_pkg::CSWD_STATUS_OFS) begin
               // Live view: stall, granted bus, current select lines
               s_axi_rdata <= {26'h0000000, cpu_stall, grant_s, select_line_n};
            end else if (s_axi_araddr[7:6] != 2'h0 || s_axi_araddr[1:0] != 2'h0) begin
               s_axi_rresp <= cswd_pkg::CSWD_RESP_SLVERR;
            end else if (rd_ofs == cswd_pkg::CSWD_CTL_OFS) begin
               s_axi_rdata <= {24'h000000, select_control_r[rd_sel]};
            end else if (rd_ofs == cswd_pkg::CSWD_LOWER_OFS) begin
               s_axi_rdata <= {24'h000000, select_lower_bound_r[rd_sel]};
            end else if (rd_ofs == cswd_pkg::CSWD_UPPER_OFS) begin
               s_axi_rdata <= {24'h000000, select_upper_bound_r[rd_sel]};
            end else begin
               s_axi_rresp <= cswd_pkg::CSWD_RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// *** verilog/cswd_pkg.sv ***
/*
 * Package for the chip-select and wait-state decoder: register map,
 * control field positions, reset values and the I/O peripheral window.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package cswd_pkg;

   // ==========================================================
   // Register map (byte addresses, one word per register)
   // ==========================================================
   // Select n: control at 0x00+n*0x10, lower at +0x4, upper at +0x8
   localparam logic [7:0] CSWD_CTL_OFS    = 8'h00;
   localparam logic [7:0] CSWD_LOWER_OFS  = 8'h04;
   localparam logic [7:0] CSWD_UPPER_OFS  = 8'h08;
   localparam logic [7:0] CSWD_STATUS_OFS = 8'h40;
   localparam int         CSWD_SEL_STRIDE = 16;

   // ==========================================================
   // Control field positions
   // ==========================================================
   localparam int CSWD_ENABLE_BIT = 3;
   localparam int CSWD_SPACE_BIT  = 4;
   localparam int CSWD_WAIT_LSB   = 5;
   localparam int CSWD_WAIT_MSB   = 7;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0] CSWD_CTL_RST     = 8'h00;
   localparam logic [7:0] CSWD_LOWER_RST   = 8'h00;
   localparam logic [7:0] CSWD_UPPER0_RST  = 8'hff;
   localparam logic [7:0] CSWD_UPPER_RST   = 8'h00;

   // ==========================================================
   // On-chip peripheral I/O window
   // ==========================================================
   localparam logic [15:0] CSWD_PERIPH_LO  = 16'h0080;
   localparam logic [15:0] CSWD_PERIPH_HI  = 16'h00ff;

   // AXI responses
   localparam logic [1:0] CSWD_RESP_OKAY   = 2'h0;
   localparam logic [1:0] CSWD_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      CSWD_IDLE,
      CSWD_WAITING,
      CSWD_EXTEND
   } cswd_state_t;

endpackage
